// ==== shared/ctt_pkg.sv ====
package ctt_pkg;
  // register addresses (16-bit address, 8-bit data bus)
  localparam logic [15:0] ADDR_STATUS_CONTROL = 16'h0008;
  localparam logic [15:0] ADDR_COUNT = 16'h0009;
  localparam logic [15:0] ADDR_WDOG_CLEAR = 16'h3ff0;
  // status/control field positions
  localparam int BIT_WRAP_FLAG = 7;
  localparam int BIT_PERIODIC_FLAG = 6;
  localparam int BIT_WRAP_EN = 5;
  localparam int BIT_PERIODIC_EN = 4;
  localparam int BIT_WRAP_CLR = 3;
  localparam int BIT_PERIODIC_CLR = 2;
  localparam int BIT_RATE_HI = 1;
  localparam int BIT_RATE_LO = 0;
  localparam int BIT_WDOG_CLR = 0;
  // reset values
  localparam logic [1:0] RATE_RESET = 2'h3;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // timing counts in bus cycles
  localparam int PRESCALE_DIV = 4;
  localparam int PRESCALE_W = 2;
  localparam int PERIODIC_CLK_DIV = 8192;
  localparam int CHAIN_W = 17;
  localparam int WDOG_DIV = 8;
  localparam int POR_CYCLES = 4064;
  localparam int POR_W = 12;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ctt_bus_req_s;

  typedef enum logic [1:0] {
    CTT_POR_HOLD,
    CTT_RUN
  } ctt_phase_e;
endpackage

// ==== verilog/ctt_tick_timer.sv ====
// How it works
// - wrap flag sets when 8-bit counter rolls from ff to 00
// - periodic flag sets when the selected divider tap goes active
// - interrupt request while a flag and its enable are both set
// - reset clears both flags and both enables
// - flag bits ignore writes; cleared only by clear bits or reset
// - wrap clear bit reads zero; writing one clears wrap flag
// - periodic clear bit reads zero; writing one clears periodic flag
// - periodic circuit fed at bus/8192, four stages and 1-of-4 tap
// - rate 00..11 gives period 2^14..2^17 bus cycles
// - reset sets both rate bits, slowest rate
// - watchdog divides periodic output by eight, then resets chip
// - writing zero to bit 0 at watchdog address clears watchdog
// - watchdog clear resets only the divide-by-eight stage
// - counter register read-only, counter steps every 4 bus cycles
// - power-on clears chain, releases after 4064 cycles, clears again
// - external reset after power-on clears entire chain
// - timer runs during wait; enabled interrupt ends wait
// - fixed divide-by-four prescaler; count at 09, status at 08
// - watchdog present only when option selected
module ctt_tick_timer #(
  parameter bit WDOG_PRESENT = 1'b1,
  parameter int POR_COUNT = ctt_pkg::POR_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic CLK_EN,
  input wire logic POWER_ON,
  input wire logic WAIT_MODE,
  input wire ctt_pkg::ctt_bus_req_s BUS_REQ,
  output logic [7:0] RDATA,
  output logic IRQ,
  output logic WAKE,
  output logic WDOG_RESET,
  output logic CHIP_RESET
);

  typedef struct packed {
    ctt_pkg::ctt_phase_e phase;
    logic [ctt_pkg::POR_W-1:0] por_cnt;
    logic [ctt_pkg::CHAIN_W-1:0] chain;
    logic [2:0] wdog;
    logic wrap_flag;
    logic per_flag;
    logic wrap_en;
    logic per_en;
    logic [1:0] rate;
    logic tap_d;
    logic wdog_pulse;
    logic [7:0] rdata;
  } ctt_state_s;

  ctt_state_s st_r;
  ctt_state_s st_nxt;

  function automatic logic sel_tap(input logic [ctt_pkg::CHAIN_W-1:0] c,
                                   input logic [1:0] r);
    sel_tap = c[13 + r];
  endfunction

  logic wr_sc;
  logic wr_wd;
  logic rd_sc;
  logic rd_cnt;
  logic [ctt_pkg::CHAIN_W-1:0] chain_inc;
  logic tap_now;
  logic tap_rise;
  logic [7:0] sc_view;

  assign wr_sc = BUS_REQ.wr && BUS_REQ.addr == ctt_pkg::ADDR_STATUS_CONTROL;
  assign wr_wd = BUS_REQ.wr && BUS_REQ.addr == ctt_pkg::ADDR_WDOG_CLEAR;
  assign rd_sc = BUS_REQ.rd && BUS_REQ.addr == ctt_pkg::ADDR_STATUS_CONTROL;
  assign rd_cnt = BUS_REQ.rd && BUS_REQ.addr == ctt_pkg::ADDR_COUNT;
  assign chain_inc = st_r.chain + 1'b1;
  assign tap_now = sel_tap(chain_inc, st_r.rate);
  assign tap_rise = tap_now && !sel_tap(st_r.chain, st_r.rate);

  always_comb begin
    sc_view = 8'h00; // clear bits read zero
    sc_view[ctt_pkg::BIT_WRAP_FLAG] = st_r.wrap_flag;
    sc_view[ctt_pkg::BIT_PERIODIC_FLAG] = st_r.per_flag;
    sc_view[ctt_pkg::BIT_WRAP_EN] = st_r.wrap_en;
    sc_view[ctt_pkg::BIT_PERIODIC_EN] = st_r.per_en;
    sc_view[ctt_pkg::BIT_RATE_HI] = st_r.rate[1];
    sc_view[ctt_pkg::BIT_RATE_LO] = st_r.rate[0];
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.wdog_pulse = 1'b0;
    st_nxt.tap_d = tap_now;
    if (BUS_REQ.rd) begin
      st_nxt.rdata = 8'h00;
    end
    unique case (st_r.phase)
      ctt_pkg::CTT_POR_HOLD: begin
        st_nxt.chain = chain_inc;
        st_nxt.por_cnt = st_r.por_cnt + 1'b1;
        if (st_r.por_cnt == POR_COUNT[ctt_pkg::POR_W-1:0] - 1'b1) begin
          st_nxt.phase = ctt_pkg::CTT_RUN;
          st_nxt.chain = '0;
        end
      end
      ctt_pkg::CTT_RUN: begin
        st_nxt.chain = chain_inc;
        if (st_r.chain[9:0] == 10'h3ff) begin
          st_nxt.wrap_flag = 1'b1;
        end
        if (tap_rise) begin
          st_nxt.per_flag = 1'b1;
          st_nxt.wdog = st_r.wdog + 1'b1;
          if (st_r.wdog == 3'h7 && WDOG_PRESENT) begin
            st_nxt.wdog_pulse = 1'b1;
          end
        end
        if (wr_sc) begin
          st_nxt.wrap_en = BUS_REQ.wdata[ctt_pkg::BIT_WRAP_EN];
          st_nxt.per_en = BUS_REQ.wdata[ctt_pkg::BIT_PERIODIC_EN];
          st_nxt.rate = {BUS_REQ.wdata[ctt_pkg::BIT_RATE_HI],
                         BUS_REQ.wdata[ctt_pkg::BIT_RATE_LO]};
          if (BUS_REQ.wdata[ctt_pkg::BIT_WRAP_CLR] &&
              !(st_r.chain[9:0] == 10'h3ff)) begin
            st_nxt.wrap_flag = 1'b0;
          end
          if (BUS_REQ.wdata[ctt_pkg::BIT_PERIODIC_CLR] && !tap_rise) begin
            st_nxt.per_flag = 1'b0;
          end
        end
        if (wr_wd && !BUS_REQ.wdata[ctt_pkg::BIT_WDOG_CLR]) begin
          st_nxt.wdog = 3'h0;
        end
        if (rd_sc) begin
          st_nxt.rdata = sc_view;
        end
        if (rd_cnt) begin
          st_nxt.rdata = st_r.chain[9:2];
        end
      end
      default: begin
        st_nxt.phase = ctt_pkg::CTT_POR_HOLD;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST || POWER_ON || st_r.wdog_pulse) begin
      st_r.phase <= POWER_ON ? ctt_pkg::CTT_POR_HOLD : st_r.phase;
      st_r.por_cnt <= '0;
      st_r.chain <= '0;
      st_r.wdog <= 3'h0;
      st_r.wrap_flag <= 1'b0;
      st_r.per_flag <= 1'b0;
      st_r.wrap_en <= 1'b0;
      st_r.per_en <= 1'b0;
      st_r.rate <= ctt_pkg::RATE_RESET;
      st_r.tap_d <= 1'b0;
      st_r.wdog_pulse <= 1'b0;
      st_r.rdata <= 8'h00;
    end else if (CLK_EN) begin
      st_r <= st_nxt;
    end
  end

  assign IRQ = (st_r.wrap_flag && st_r.wrap_en) ||
               (st_r.per_flag && st_r.per_en);
  assign WAKE = WAIT_MODE && IRQ;
  assign WDOG_RESET = st_r.wdog_pulse;
  assign CHIP_RESET = st_r.phase == ctt_pkg::CTT_POR_HOLD || st_r.wdog_pulse;
  assign RDATA = st_r.rdata;

  a_irq_request: assert property (@(posedge SYS_CLK) disable iff (SRST)
    IRQ == ((st_r.wrap_flag && st_r.wrap_en) || (st_r.per_flag && st_r.per_en)))
    else $error("irq does not match flags and enables");
  a_wrap_sets: assert property (@(posedge SYS_CLK) disable iff (SRST || POWER_ON)
    CLK_EN && st_r.phase == ctt_pkg::CTT_RUN && st_r.chain[9:0] == 10'h3ff
    |=> st_r.wrap_flag)
    else $error("wrap flag not set on roll over");
  a_reset_clears: assert property (@(posedge SYS_CLK)
    SRST |=> !st_r.wrap_flag && !st_r.per_flag && !st_r.wrap_en &&
    st_r.rate == 2'h3)
    else $error("reset values wrong");
  a_wdog_clear: assert property (@(posedge SYS_CLK) disable iff (SRST || POWER_ON)
    CLK_EN && wr_wd && !BUS_REQ.wdata[0] && st_r.phase == ctt_pkg::CTT_RUN
    && !st_r.wdog_pulse |=> st_r.wdog == 3'h0)
    else $error("watchdog not cleared");
  a_per_flag_set: assert property (@(posedge SYS_CLK) disable iff (SRST || POWER_ON)
    CLK_EN && st_r.phase == ctt_pkg::CTT_RUN && tap_rise && !st_r.wdog_pulse
    |=> st_r.per_flag)
    else $error("periodic flag missed");
  a_flag_ro: assert property (@(posedge SYS_CLK) disable iff (SRST || POWER_ON)
    !st_r.wrap_flag && !(st_r.chain[9:0] == 10'h3ff) ##0 !st_r.wdog_pulse
    |=> !st_r.wrap_flag)
    else $error("wrap flag set without roll over");
  a_wrap_clear: assert property (@(posedge SYS_CLK) disable iff (SRST || POWER_ON)
    CLK_EN && wr_sc && BUS_REQ.wdata[3] && st_r.phase == ctt_pkg::CTT_RUN &&
    st_r.chain[9:0] != 10'h3ff |=> !st_r.wrap_flag)
    else $error("wrap flag not cleared");
  a_clr_reads0: assert property (@(posedge SYS_CLK) disable iff (SRST)
    $past(rd_sc) && $past(CLK_EN) |-> RDATA[3:2] == 2'h0)
    else $error("clear bits read nonzero");
endmodule

// ==== testbench/ctt_tick_timer_bench.sv ====
module ctt_tick_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SC = ctt_pkg::ADDR_STATUS_CONTROL;
  localparam logic [15:0] CN = ctt_pkg::ADDR_COUNT;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic pwr = 1'b1;
  logic wmode = 1'b0;
  ctt_pkg::ctt_bus_req_s req = '0;
  logic [7:0] rdata;
  logic irq, wake, wdog, chip;
  logic [7:0] v, w;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int t0, n;
  always #2.5 clk = ~clk;
  ctt_tick_timer #(.POR_COUNT(16)) DUT (.SYS_CLK(clk), .SRST(srst),
    .CLK_EN(1'b1), .POWER_ON(pwr), .WAIT_MODE(wmode), .BUS_REQ(req),
    .RDATA(rdata), .IRQ(irq), .WAKE(wake), .WDOG_RESET(wdog),
    .CHIP_RESET(chip));
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a; req.wdata <= d; req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a; req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic poll(input int b, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd(SC, v);
      if (v[b] === 1'b1) break;
    end
  endtask
  task automatic t_reset;
    rd(SC, v); chk(v, 8'h03);
    rd(16'h0007, v); chk(v, 8'h00);
    rd(CN, v); repeat (6) @(posedge clk);
    rd(CN, w); chk(w - v, 8'h02);
  endtask
  task automatic t_wrap;
    poll(7, 700); chk(v, 8'h83);
    wr(ctt_pkg::ADDR_WDOG_CLEAR, 8'h00);
    wr(SC, 8'hc0); rd(SC, v); chk(v, 8'h80);
    chk({7'h0, irq}, 8'h00);
    wr(SC, 8'h20); chk({7'h0, irq}, 8'h01);
    wr(SC, 8'h28); chk({7'h0, irq}, 8'h00);
    rd(SC, v); chk(v, 8'h20);
  endtask
  task automatic t_periodic;
    wr(ctt_pkg::ADDR_WDOG_CLEAR, 8'h00);
    wr(SC, 8'h10); poll(6, 12000);
    t0 = cycles;
    chk(v & 8'h7f, 8'h50);
    chk({irq, wdog}, 8'h02);
    wmode <= 1'b1; @(posedge clk); #1;
    chk({7'h0, wake}, 8'h01);
    wmode <= 1'b0;
    wr(SC, 8'h14); chk({7'h0, irq}, 8'h00);
    rd(SC, v); chk(v & 8'h7f, 8'h10);
    poll(6, 9000);
    n = cycles - t0;
    chk({7'h0, n > 16380 && n < 16390}, 8'h01);
  endtask
  task automatic t_srst;
    @(posedge clk); srst <= 1'b1; @(posedge clk); srst <= 1'b0;
    rd(CN, v); chk(v, 8'h00);
    rd(SC, v); chk(v, 8'h03);
  endtask
  task automatic t_por;
    @(posedge clk); pwr <= 1'b1; @(posedge clk); pwr <= 1'b0;
    @(posedge clk); #1;
    n = 0;
    while (chip === 1'b1 && n < 100) begin
      n++; @(posedge clk); #1;
    end
    chk(n[7:0], 8'h0f);
    rd(CN, v); chk(v, 8'h00);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0; pwr <= 1'b0;
    for (int i = 0; i < 100 && chip !== 1'b0; i++) @(posedge clk);
    t_reset();
    t_wrap();
    t_periodic();
    t_srst();
    t_por();
    wrap_up();
  end
endmodule
